// File: inc/radio_map.svh
// offsets, field positions, codes and timing counts of the radio control block
// assumes a 10 MHz system clock and byte addresses on the register bus
`ifndef RADIO_MAP_SVH
`define RADIO_MAP_SVH
`define ADR_STATE 9'h000
`define ADR_PIN 9'h004
`define ADR_CTRL2 9'h008
`define ADR_SYNC 9'h00C
`define ADR_TXPWR 9'h010
`define ADR_ED 9'h014
`define ADR_RSSI 9'h018
`define ADR_RXLEN 9'h01C
`define ADR_BUF_LO 9'h180
`define BIT_SLP 1
`define BIT_DYN 7
`define BIT_ACRC 5
`define BIT_PDT_DIS 7
`define BIT_FCS_OK 7
`define CMD_NOP 5'h00
`define CMD_TX_START 5'h02
`define CMD_OFF 5'h08
`define CMD_PLL_ON 5'h09
`define CMD_RX_ON 5'h06
`define CMD_AACK_ON 5'h16
`define CMD_ARET_ON 5'h19
`define RST_THR 4'h0
`define RST_PWR 4'h0
`define CLK_MHZ 10
`define TX_START_US 16
`define PA_BUF_US 2
`define PA_US 8
`define TX_START_CYC (`TX_START_US * `CLK_MHZ)
`define PA_BUF_CYC (`PA_BUF_US * `CLK_MHZ)
`define PA_CYC (`PA_US * `CLK_MHZ)
`define CHIP_DIV 3'h4
`define FREQ_LIMIT_PPM 8'sd120
`define PWR_SPAN_DB 20
`define CHIP_BASE 32'h744AC39B
`define CRC_POLY 16'h8408
`endif

// File: inc/radio_pkg.sv
// types of the radio frame control block
// assumes radio_map.svh is compiled alongside
package radio_pkg;
  typedef enum logic [4:0] {
    radio_off_state = 5'h08,
    pll_on_state = 5'h09,
    rx_on_state = 5'h06,
    busy_rx_state = 5'h01,
    tx_busy_state = 5'h02,
    aack_on_state = 5'h16,
    busy_aack_state = 5'h11,
    auto_retry_tx_state = 5'h19,
    busy_aret_state = 5'h12
  } radio_state_t;

  typedef enum logic [1:0] {
    tx_idle = 2'b00,
    tx_ramp = 2'b01,
    tx_send = 2'b10
  } tx_phase_t;

  typedef struct packed {
    logic [127:0][7:0] mem;
    radio_state_t state;
    tx_phase_t tx;
    logic ack;
    logic [31:0] rdat;
    logic slp;
    logic dyn;
    logic acrc;
    logic pdt_dis;
    logic [3:0] thr;
    logic [3:0] pwr;
    logic [7:0] ed;
    logic [4:0] rssi;
    logic fcs_ok;
    logic [6:0] rxlen;
    logic [6:0] wptr;
    logic [7:0] lqi;
    logic lock;
    logic irq_b;
    logic irq_d;
    logic demod;
    logic [7:0] fcorr;
    logic [7:0] ramp;
    logic [2:0] div;
    logic [4:0] chip;
    logic symhi;
    logic [6:0] bidx;
    logic [15:0] crc;
    logic pab;
    logic pa;
    logic ti;
    logic tq;
    logic tv;
  } radio_regs_t;
endpackage

// File: src/radio_frame_rx_tx_control.sv
// receive and transmit frame control of a 2.4 GHz radio, with frame buffer
// assumes a classic Wishbone master and receive baseband on i_clock
//
// The implementer's own choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/100ps
`include "radio_map.svh"

module radio_frame_rx_tx_control (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [8:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic i_rx_sync,
  input wire logic i_rx_byte_vld,
  input wire logic [7:0] i_rx_byte,
  input wire logic [7:0] i_rx_corr,
  input wire logic i_rx_end,
  input wire logic i_rx_fcs_ok,
  input wire logic [4:0] i_rssi,
  input wire logic [7:0] i_ed,
  input wire logic signed [7:0] i_freq_est,
  output logic o_rx_frame_begin_irq,
  output logic o_rx_frame_done_irq,
  output logic o_demod_en,
  output logic [7:0] o_freq_corr,
  output radio_pkg::radio_state_t o_state,
  output logic [3:0] o_output_power,
  output logic o_pa_buf_en,
  output logic o_pa_en,
  output logic o_tx_i,
  output logic o_tx_q,
  output logic o_tx_valid
);
  import radio_pkg::*;

  radio_regs_t r_q;
  radio_regs_t r_d;
  logic [15:0] crc_nx;
  logic [4:0] cmd;
  logic listen;
  logic trig;
  logic [7:0] tbyte;
  logic [3:0] sym;
  logic signed [7:0] fclip;

  // ****************************************
  // helper functions
  // ****************************************

  // chip k of a symbol: base rotated by 4 per symbol, odd chips flipped above 7
  function automatic logic chip_of(input logic [3:0] s, input logic [4:0] k);
    logic [31:0] b;
    logic [4:0] j;
    logic c;
    b = `CHIP_BASE;
    j = k - {s[2:0], 2'b00};
    c = b[j];
    if (s[3] && k[0]) begin
      c = ~c;
    end
    return c;
  endfunction

  // checksum over one byte, least significant bit first
  function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                           input logic [7:0] d);
    logic [15:0] x;
    x = c;
    for (int i = 0; i < 8; i++) begin
      if (x[0] ^ d[i]) begin
        x = (x >> 1) ^ `CRC_POLY;
      end else begin
        x = x >> 1;
      end
    end
    return x;
  endfunction

  // ****************************************
  // next state
  // ****************************************

  // frequently used decodes
  always_comb begin
    cmd = i_wb_dat[4:0];
    listen = (r_q.state == rx_on_state) || (r_q.state == aack_on_state);
    tbyte = r_q.mem[r_q.bidx];
    sym = r_q.symhi ? tbyte[7:4] : tbyte[3:0];
    // the length byte stays out of the checksum
    crc_nx = (r_q.bidx == 7'h00) ? r_q.crc : crc_byte(r_q.crc, tbyte);
    fclip = (i_freq_est > `FREQ_LIMIT_PPM) ? `FREQ_LIMIT_PPM :
            (i_freq_est < -`FREQ_LIMIT_PPM) ? -`FREQ_LIMIT_PPM :
            i_freq_est;
  end

  always_comb begin
    r_d = r_q;
    trig = 1'b0;
    r_d.ack = 1'b0;
    r_d.irq_b = 1'b0;
    r_d.irq_d = 1'b0;
    // bus slave: one wait state, unmapped reads give zero, writes dropped
    if (i_wb_cyc && i_wb_stb && !r_q.ack) begin
      r_d.ack = 1'b1;
      r_d.rdat = 32'h0000_0000;
      if (i_wb_adr >= `ADR_BUF_LO) begin
        for (int b = 0; b < 4; b++) begin
          r_d.rdat[b*8 +: 8] = r_q.mem[{i_wb_adr[6:2], 2'(b)}];
          if (i_wb_we && i_wb_sel[b]) begin
            r_d.mem[{i_wb_adr[6:2], 2'(b)}] = i_wb_dat[b*8 +: 8];
          end
        end
      end else begin
        unique case ({i_wb_adr[8:2], 2'b00})
          `ADR_STATE: r_d.rdat[4:0] = r_q.state;
          `ADR_PIN: r_d.rdat[`BIT_SLP] = r_q.slp;
          `ADR_CTRL2: begin
            r_d.rdat[`BIT_DYN] = r_q.dyn;
            r_d.rdat[`BIT_ACRC] = r_q.acrc;
          end
          `ADR_SYNC: begin
            r_d.rdat[`BIT_PDT_DIS] = r_q.pdt_dis;
            r_d.rdat[3:0] = r_q.thr;
          end
          `ADR_TXPWR: r_d.rdat[3:0] = r_q.pwr;
          `ADR_ED: r_d.rdat[7:0] = r_q.ed;
          `ADR_RSSI: begin
            r_d.rdat[`BIT_FCS_OK] = r_q.fcs_ok;
            r_d.rdat[4:0] = r_q.rssi;
          end
          `ADR_RXLEN: r_d.rdat[6:0] = r_q.rxlen;
          default: r_d.rdat = 32'h0000_0000;
        endcase
        if (i_wb_we) begin
          unique case ({i_wb_adr[8:2], 2'b00})
            `ADR_STATE: if (i_wb_sel[0]) begin
              unique case (cmd)
                `CMD_TX_START: trig = 1'b1;
                `CMD_RX_ON: if (r_q.state == radio_off_state ||
                                r_q.state == pll_on_state) begin
                  r_d.state = rx_on_state;
                end
                `CMD_AACK_ON: if (r_q.state == radio_off_state ||
                                  r_q.state == pll_on_state) begin
                  r_d.state = aack_on_state;
                end
                `CMD_ARET_ON: if (r_q.state == radio_off_state ||
                                  r_q.state == pll_on_state) begin
                  r_d.state = auto_retry_tx_state;
                end
                `CMD_PLL_ON: if (r_q.tx == tx_idle &&
                                 r_q.state != busy_rx_state &&
                                 r_q.state != busy_aack_state) begin
                  r_d.state = pll_on_state;
                end
                `CMD_OFF: if (r_q.tx == tx_idle &&
                              r_q.state != busy_rx_state &&
                              r_q.state != busy_aack_state) begin
                  r_d.state = radio_off_state;
                end
                default: r_d.state = r_q.state;
              endcase
            end
            `ADR_PIN: if (i_wb_sel[0]) begin
              r_d.slp = i_wb_dat[`BIT_SLP];
              trig = i_wb_dat[`BIT_SLP] && !r_q.slp;
            end
            `ADR_CTRL2: if (i_wb_sel[0]) begin
              r_d.dyn = i_wb_dat[`BIT_DYN];
              r_d.acrc = i_wb_dat[`BIT_ACRC];
            end
            `ADR_SYNC: if (i_wb_sel[0]) begin
              r_d.pdt_dis = i_wb_dat[`BIT_PDT_DIS];
              r_d.thr = i_wb_dat[3:0];
            end
            `ADR_TXPWR: if (i_wb_sel[0]) begin
              r_d.pwr = i_wb_dat[3:0];
            end
            default: r_d.slp = r_d.slp;
          endcase
        end
      end
    end
    // protection lasts only while software keeps the bit set
    if (!r_d.dyn) begin
      r_d.lock = 1'b0;
    end
    // threshold, disable and protection all gate the demodulator
    r_d.demod = listen && !r_q.pdt_dis && !r_q.lock &&
                (i_rssi >= {1'b0, r_q.thr});
    // receive: a sync header is only taken while the demodulator is open
    if (listen && r_q.demod && i_rx_sync) begin
      r_d.state = (r_q.state == rx_on_state) ? busy_rx_state
                                              : busy_aack_state;
      r_d.irq_b = 1'b1;
      r_d.wptr = 7'h00;
      r_d.lqi = 8'h00;
      r_d.fcorr = 8'(-fclip);
    end
    if (r_q.state == busy_rx_state || r_q.state == busy_aack_state) begin
      if (i_rx_byte_vld) begin
        r_d.mem[r_q.wptr] = i_rx_byte;
        r_d.wptr = r_q.wptr + 7'h01;
        // running average of symbol correlation as link quality
        r_d.lqi = r_q.lqi - (r_q.lqi >> 3) + (i_rx_corr >> 3);
      end
      if (i_rx_end) begin
        r_d.mem[r_q.wptr] = r_q.lqi;
        r_d.rxlen = r_q.wptr;
        r_d.ed = i_ed;
        r_d.rssi = i_rssi;
        r_d.fcs_ok = i_rx_fcs_ok;
        r_d.lock = r_q.dyn && i_rx_fcs_ok;
        r_d.irq_d = 1'b1;
        r_d.fcorr = 8'h00;
        r_d.state = (r_q.state == busy_rx_state) ? rx_on_state
                                                  : aack_on_state;
      end
    end
    // start only from pll or auto-retry; everything else drops the trigger
    if (trig && r_q.tx == tx_idle && (r_q.state == pll_on_state ||
        r_q.state == auto_retry_tx_state)) begin
      r_d.state = (r_q.state == pll_on_state) ? tx_busy_state
                                               : busy_aret_state;
      r_d.tx = tx_ramp;
      r_d.ramp = 8'h01;
    end
    // transmit: ramp the amplifier chain, then stream chips
    unique case (r_q.tx)
      tx_idle: r_d.tv = 1'b0;
      tx_ramp: begin
        r_d.ramp = r_q.ramp + 8'h01;
        if (r_q.ramp == 8'(`PA_BUF_CYC)) begin
          r_d.pab = 1'b1;
        end
        if (r_q.ramp == 8'(`PA_CYC)) begin
          r_d.pa = 1'b1;
        end
        if (r_q.ramp == 8'(`TX_START_CYC)) begin
          r_d.tx = tx_send;
          r_d.bidx = 7'h00;
          r_d.symhi = 1'b0;
          r_d.chip = 5'h00;
          r_d.div = 3'h0;
          r_d.crc = 16'h0000;
          r_d.tv = 1'b1;
        end
      end
      tx_send: begin
        r_d.div = (r_q.div == `CHIP_DIV) ? 3'h0 : r_q.div + 3'h1;
        // the last chip has stood four of its five cycles: stop the chain
        if (r_q.ramp == 8'h00 && r_q.div == `CHIP_DIV) begin
          r_d.tx = tx_idle;
          r_d.tv = 1'b0;
          r_d.pa = 1'b0;
          r_d.pab = 1'b0;
          r_d.state = (r_q.state == tx_busy_state) ? pll_on_state
                                                    : auto_retry_tx_state;
        end
        if (r_q.div == 3'h0) begin
          // even chips to i, odd chips to q: q trails i by one chip time
          if (r_q.chip[0]) begin
            r_d.tq = chip_of(sym, r_q.chip);
          end else begin
            r_d.ti = chip_of(sym, r_q.chip);
          end
          r_d.chip = r_q.chip + 5'h01;
          if (r_q.chip == 5'h1F) begin
            r_d.symhi = ~r_q.symhi;
            if (r_q.symhi) begin
              r_d.bidx = r_q.bidx + 7'h01;
              r_d.crc = crc_nx;
              // swap in the checksum before its bytes go out
              if (r_q.acrc && r_q.bidx == r_q.mem[0][6:0] - 7'h02) begin
                r_d.mem[r_q.bidx + 7'h01] = crc_nx[7:0];
              end
              if (r_q.acrc && r_q.bidx == r_q.mem[0][6:0] - 7'h01) begin
                r_d.mem[r_q.bidx + 7'h01] = r_q.crc[15:8];
              end
              // last chip just went out; ramp marks the stop
              if (r_q.bidx == r_q.mem[0][6:0]) begin
                r_d.ramp = 8'h00;
              end
            end
          end
        end
      end
      default: r_d.tx = tx_idle;
    endcase
  end

  // ****************************************
  // state register
  // ****************************************

  // buffer contents are not cleared by reset, only control state is
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      r_q <= '0;
      r_q.mem <= r_q.mem;
      r_q.state <= radio_off_state;
      r_q.tx <= tx_idle;
      r_q.thr <= `RST_THR;
      r_q.pwr <= `RST_PWR;
    end else begin
      r_q <= r_d;
    end
  end

  // outputs straight from the state register
  always_comb begin
    o_wb_dat = r_q.rdat;
    o_wb_ack = r_q.ack;
    o_rx_frame_begin_irq = r_q.irq_b;
    o_rx_frame_done_irq = r_q.irq_d;
    o_demod_en = r_q.demod;
    o_freq_corr = r_q.fcorr;
    o_state = r_q.state;
    o_output_power = r_q.pwr;
    o_pa_buf_en = r_q.pab;
    o_pa_en = r_q.pa;
    o_tx_i = r_q.ti;
    o_tx_q = r_q.tq;
    o_tx_valid = r_q.tv;
  end
endmodule // radio_frame_rx_tx_control

// File: tb/radio_frame_rx_tx_control_props.sv
// checker of the radio frame control block: timing of events and ramp
// assumes binding onto the block's top module, one clock, sync reset
`timescale 1ns/100ps
// ****
// event and ramp checks
// ****
module radio_ctrl_props
  import radio_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_rx_sync,
  input wire logic i_rx_end,
  input wire logic o_demod_en,
  input wire radio_pkg::radio_state_t o_state,
  input wire logic o_rx_frame_begin_irq,
  input wire logic o_rx_frame_done_irq,
  input wire logic o_pa_buf_en,
  input wire logic o_pa_en,
  input wire logic o_tx_valid,
  input wire logic [7:0] o_freq_corr
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  // listening states are the only ones that accept a sync header
  wire listen = (o_state == rx_on_state) || (o_state == aack_on_state);
  wire busy_rx = (o_state == busy_rx_state) || (o_state == busy_aack_state);
  sequence pa_late_s;
    ##60 $rose(o_pa_en);
  endsequence
  sequence mod_late_s;
    ##80 $rose(o_tx_valid);
  endsequence
  AST_BEGIN: assert property (i_rx_sync && o_demod_en && listen |=> o_rx_frame_begin_irq)
    else $error("begin pulse missing");
  AST_BEGIN_STATE: assert property (o_rx_frame_begin_irq |-> busy_rx)
    else $error("begin pulse outside busy state");
  AST_DONE: assert property (i_rx_end && busy_rx |=> o_rx_frame_done_irq && listen)
    else $error("done pulse or return missing");
  AST_NO_DEMOD: assert property (i_rx_sync && !o_demod_en |=> !o_rx_frame_begin_irq)
    else $error("sync taken while demodulation off");
  AST_FREQ_CLIP: assert property (o_freq_corr <= 8'h78 || o_freq_corr >= 8'h88)
    else $error("frequency correction beyond limit");
  AST_TX_STATE: assert property ($rose(o_pa_buf_en) |-> o_state == tx_busy_state || o_state == busy_aret_state)
    else $error("ramp without transmit state");
  AST_PA_GAP: assert property ($rose(o_pa_buf_en) |-> pa_late_s)
    else $error("amplifier not after buffer");
  AST_MOD_GAP: assert property ($rose(o_pa_en) |-> mod_late_s)
    else $error("modulation start late or early");
  AST_VALID_PA: assert property (o_tx_valid |-> o_pa_en && o_pa_buf_en)
    else $error("chips without amplifier");
endmodule // radio_ctrl_props

// File: tb/rx_air_model.sv
// far-side radio: drives the receive link of the block with frames
// assumes the bench calls frame() from its main sequence
`timescale 1ns/100ps
// ****
// remote transmitter seen through the receive baseband
// ****
module rx_air_model (
  input wire logic i_clock,
  output logic o_sync,
  output logic o_vld,
  output logic [7:0] o_byte,
  output logic [7:0] o_corr,
  output logic o_end,
  output logic o_fcs_ok,
  output logic [7:0] o_ed,
  output logic signed [7:0] o_freq
);
  initial begin
    o_sync = 1'b0;
    o_vld = 1'b0;
    o_byte = 8'h5A;
    o_corr = 8'h00;
    o_end = 1'b0;
    o_fcs_ok = 1'b0;
    o_ed = 8'h00;
    o_freq = 8'sh00;
  end
  // n of zero is a stray header with no body; idle lines other than o_corr show inverse
  task automatic frame(input logic [7:0] key, input int n, input logic ok);
    @(posedge i_clock);
    o_sync <= 1'b1;
    o_freq <= 8'($urandom);
    @(posedge i_clock);
    o_sync <= 1'b0;
    o_freq <= ~o_freq;
    for (int k = 0; k < n; k++) begin
      @(posedge i_clock);
      o_vld <= 1'b1;
      o_byte <= key + 8'(k);
      o_corr <= 8'($urandom);
      @(posedge i_clock);
      o_vld <= 1'b0;
      o_byte <= ~o_byte;
    end
    if (n > 0) begin
      @(posedge i_clock);
      o_end <= 1'b1;
      o_fcs_ok <= ok;
      o_ed <= key;
      @(posedge i_clock);
      o_end <= 1'b0;
      o_fcs_ok <= ~ok;
      o_ed <= ~key;
    end
    // let the block's event pulses be counted before returning
    repeat (2) @(posedge i_clock);
  endtask
endmodule // rx_air_model

// File: tb/testbench.sv
// self-checking bench of the radio frame control block
// assumes radio_map.svh on the include path, 10 MHz clock
`timescale 1ns/100ps
`include "radio_map.svh"
// ****
// bench top
// ****
module testbench;
  import radio_pkg::*;
  logic i_clock, i_rst, i_wb_cyc, i_wb_stb, i_wb_we;
  logic [8:0] i_wb_adr;
  logic [3:0] i_wb_sel;
  logic [31:0] i_wb_dat, o_wb_dat;
  logic o_wb_ack, i_rx_sync, i_rx_byte_vld, i_rx_end, i_rx_fcs_ok;
  logic [7:0] i_rx_byte, i_rx_corr, i_ed, o_freq_corr;
  logic signed [7:0] i_freq_est;
  logic [4:0] i_rssi;
  logic o_rx_frame_begin_irq, o_rx_frame_done_irq, o_demod_en;
  logic o_pa_buf_en, o_pa_en, o_tx_i, o_tx_q, o_tx_valid;
  logic [3:0] o_output_power;
  radio_state_t o_state;
  logic [63:0] exp_q[$];
  logic [63:0] e;
  logic [7:0] key, thr, pw, len;
  logic c0;
  int err_total = 0, total_checks = 0, nb = 0, nd = 0, n, m;

  radio_frame_rx_tx_control dut (.i_clock, .i_rst, .i_wb_cyc, .i_wb_stb,
    .i_wb_we, .i_wb_adr, .i_wb_sel, .i_wb_dat, .o_wb_dat, .o_wb_ack,
    .i_rx_sync, .i_rx_byte_vld, .i_rx_byte, .i_rx_corr, .i_rx_end,
    .i_rx_fcs_ok, .i_rssi, .i_ed, .i_freq_est, .o_rx_frame_begin_irq,
    .o_rx_frame_done_irq, .o_demod_en, .o_freq_corr, .o_state,
    .o_output_power, .o_pa_buf_en, .o_pa_en, .o_tx_i, .o_tx_q, .o_tx_valid);
  rx_air_model air (.i_clock, .o_sync(i_rx_sync), .o_vld(i_rx_byte_vld),
    .o_byte(i_rx_byte), .o_corr(i_rx_corr), .o_end(i_rx_end),
    .o_fcs_ok(i_rx_fcs_ok), .o_ed(i_ed), .o_freq(i_freq_est));

  initial begin
    i_clock = 1'b0;
    forever #50 i_clock = ~i_clock;
  end

  task automatic check(input logic [31:0] g, input logic [31:0] x);
    total_checks++;
    if (g !== x) begin
      err_total++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  // one classic cycle; the note of the expected answer goes first
  task automatic wb(input logic w, input logic [8:0] a,
                    input logic [31:0] d, input logic [31:0] msk);
    exp_q.push_back({msk, d & msk});
    @(posedge i_clock);
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we <= w;
    i_wb_adr <= a;
    i_wb_dat <= d;
    @(posedge i_clock);
    while (o_wb_ack !== 1'b1) @(posedge i_clock);
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
  endtask
  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    wb(1'b1, a, d, 32'h0);
  endtask
  task automatic rd(input logic [8:0] a, input logic [31:0] d,
                    input logic [31:0] msk);
    wb(1'b0, a, d, msk);
  endtask
  function automatic logic [31:0] wexp(input logic [7:0] k);
    return {k + 8'h3, k + 8'h2, k + 8'h1, k};
  endfunction
  // first chip of a symbol: base sequence rotated by four chips per symbol
  function automatic logic chip0(input logic [3:0] s);
    logic [31:0] b;
    b = `CHIP_BASE;
    return b[5'h00 - {s[2:0], 2'b00}];
  endfunction
  // checksum of one byte, least significant bit first, start value zero
  function automatic logic [15:0] crc16(input logic [7:0] d);
    logic [15:0] c;
    c = 16'h0000;
    for (int i = 0; i < 8; i++) begin
      c = (c[0] ^ d[i]) ? ((c >> 1) ^ `CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction
  // cycles from trigger to chips, then length of the chip stream
  task automatic tx_run;
    n = 0;
    m = 0;
    while (o_tx_valid !== 1'b1) begin
      @(posedge i_clock);
      n++;
    end
    while (o_tx_valid === 1'b1) begin
      @(posedge i_clock);
      m++;
      if (m == 1) c0 = o_tx_i;
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // watcher: takes the oldest note whenever an answer shows
  always @(posedge i_clock) begin
    if (o_rx_frame_begin_irq === 1'b1) nb++;
    if (o_rx_frame_done_irq === 1'b1) nd++;
    if (o_wb_ack === 1'b1 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      if (e[63:32] != 32'h0) check(o_wb_dat & e[63:32], e[31:0]);
    end
  end

  // hang guard, far above the few thousand cycles of the sequence
  initial begin
    repeat (20000) @(posedge i_clock);
    err_total++;
    end_sim;
  end

  initial begin
    void'($urandom(32'h0F43));
    i_rst = 1'b1;
    i_wb_cyc = 1'b0;
    i_wb_stb = 1'b0;
    i_wb_we = 1'b0;
    i_wb_adr = 9'h000;
    i_wb_sel = 4'hF;
    i_wb_dat = 32'h0;
    i_rssi = 5'h00;
    repeat (20) @(posedge i_clock);
    i_rst <= 1'b0;
    rd(`ADR_STATE, 32'h08, 32'h1F);
    rd(9'h040, 32'h0, 32'hFFFFFFFF);
    pw = 8'($urandom % 16);
    wr(`ADR_TXPWR, pw);
    check(o_output_power, pw);
    rd(`ADR_TXPWR, pw, 32'hF);
    thr = 8'(1 + $urandom % 15);
    i_rssi <= thr[4:0] - 5'h01;
    wr(`ADR_SYNC, thr);
    wr(`ADR_CTRL2, 32'h80);
    wr(`ADR_STATE, `CMD_RX_ON);
    rd(`ADR_STATE, `CMD_RX_ON, 32'h1F);
    air.frame(8'h11, 0, 1'b1);
    check(o_demod_en, 32'h0);
    check(nb, 32'h0);
    i_rssi <= thr[4:0] + 5'($urandom % 16);
    key = 8'($urandom);
    air.frame(key, 5, 1'b1);
    rd(`ADR_RXLEN, 32'h5, 32'h7F);
    check(nb, 32'h1);
    check(nd, 32'h1);
    rd(`ADR_BUF_LO, wexp(key), 32'hFFFFFFFF);
    rd(`ADR_ED, key, 32'hFF);
    rd(`ADR_RSSI, 32'h80, 32'h80);
    air.frame(8'h22, 0, 1'b1);
    rd(`ADR_STATE, `CMD_RX_ON, 32'h1F);
    check(nb, 32'h1);
    wr(`ADR_CTRL2, 32'h0);
    wr(`ADR_CTRL2, 32'h80);
    air.frame(8'h33, 3, 1'b0);
    rd(`ADR_RSSI, 32'h0, 32'h80);
    key = ~key;
    air.frame(key, 4, 1'b1);
    check(nb, 32'h3);
    rd(`ADR_BUF_LO, wexp(key), 32'hFFFFFFFF);
    wr(`ADR_CTRL2, 32'h0);
    wr(`ADR_SYNC, 32'h80 | thr);
    air.frame(8'h44, 0, 1'b1);
    check(o_demod_en, 32'h0);
    check(nb, 32'h3);
    rd(`ADR_STATE, `CMD_RX_ON, 32'h1F);
    wr(`ADR_SYNC, thr);
    wr(`ADR_STATE, `CMD_OFF);
    wr(`ADR_STATE, `CMD_AACK_ON);
    rd(`ADR_STATE, `CMD_AACK_ON, 32'h1F);
    wr(`ADR_STATE, `CMD_TX_START);
    rd(`ADR_STATE, `CMD_AACK_ON, 32'h1F);
    wr(`ADR_PIN, 32'h2);
    rd(`ADR_STATE, `CMD_AACK_ON, 32'h1F);
    wr(`ADR_PIN, 32'h0);
    wr(`ADR_STATE, `CMD_OFF);
    wr(`ADR_STATE, `CMD_PLL_ON);
    len = 8'(1 + $urandom % 3);
    wr(`ADR_BUF_LO, {24'($urandom), len});
    wr(`ADR_PIN, 32'h2);
    check(o_state, tx_busy_state);
    tx_run;
    check(n, `TX_START_CYC);
    check(m, (len + 1) * 320);
    check(c0, chip0(len[3:0]));
    rd(`ADR_STATE, `CMD_PLL_ON, 32'h1F);
    wr(`ADR_PIN, 32'h0);
    wr(`ADR_STATE, `CMD_TX_START);
    check(o_state, tx_busy_state);
    tx_run;
    check(n, `TX_START_CYC);
    check(c0, chip0(len[3:0]));
    len = 8'h03;
    key = 8'($urandom);
    wr(`ADR_BUF_LO, {16'h0000, key, len});
    wr(`ADR_CTRL2, 32'h20);
    wr(`ADR_STATE, `CMD_ARET_ON);
    wr(`ADR_PIN, 32'h2);
    check(o_state, busy_aret_state);
    tx_run;
    check(m, (len + 1) * 320);
    check(c0, chip0(len[3:0]));
    rd(`ADR_BUF_LO, {crc16(key), key, len}, 32'hFFFFFFFF);
    rd(`ADR_STATE, `CMD_ARET_ON, 32'h1F);
    end_sim;
  end
endmodule // testbench

bind radio_frame_rx_tx_control radio_ctrl_props props (.i_clock, .i_rst,
  .i_rx_sync, .i_rx_end, .o_demod_en, .o_state, .o_rx_frame_begin_irq,
  .o_rx_frame_done_irq, .o_pa_buf_en, .o_pa_en, .o_tx_valid, .o_freq_corr);
